/* File: ebp_dev.sv */
// Purpose: Device end of external bus port: master requests out, slave access in
// Assumes: Pin inputs synchronous to mclk except the async reset input
// Notes:   Master transfer and slave service share one state machine
//
// Behaviour
// - Tri-state all outputs while reset active; reset-complete is driven low instead
// - Outputs can tri-state in normal operation
// - Async inputs pass a two-flop synchronizer
// - Reset input forces known idle state
// - Drive reset-complete after reset; board loops it
// - Master drives access address on address bus
// - Bus master alone drives remote access address
// - Data bus both driven and received
// - Master asserts read strobe on every read
// - Slave sees read strobe as read marker
// - Only bus master drives read, low-write strobes
// - Strobes change in the address cycle
// - Low-write strobe on even-word writes
// - Low-write strobe on every 32-bit zone write
// - Far master uses low-write for low word
// - Slave sees low-write strobe as write marker
// - High-write strobe for 64-bit, odd-word writes outside 32-bit zones
// - Slave deasserts acknowledge for wait states
`timescale 1ns/1ps
module ebp_dev
   import ebp_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_in_async,
   // User master requests
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire ebp_req_t          req,
   input  wire logic              bus_grant,
   input  wire logic              float_bus,
   // User read answers
   output logic [DATA_W-1:0]      rd_data_q,
   output logic                   rd_valid_q,
   // Slave service hold-off
   input  wire logic              slave_wait,
   // Status
   output logic                   reset_done_q,
   // Pins
   ebp_if.dev                     bus
);
   typedef enum logic [2:0] {ST_RESET, ST_IDLE, ST_ADDR, ST_DATA, ST_SLAVE, ST_SLV_END} ebp_state_t;

   logic [SYNC_STAGES-1:0] rst_sync_q;
   logic                   rst;
   logic [RST_CNT_W-1:0]   rst_cnt_q;
   ebp_state_t             st_q;
   ebp_req_t               cur_q;
   ebp_req_t               fifo_out;
   logic                   fifo_valid;
   logic                   fifo_pop;
   logic [DATA_W-1:0]      mem_q [2**MEM_AW];
   logic                   slv_sel;
   logic [ADDR_W-1:0]      addr_o_q;
   logic [DATA_W-1:0]      data_o_q;
   logic                   addr_oe_q;
   logic                   data_oe_q;
   logic                   ctl_oe_q;
   logic                   rd_o_q;
   logic                   wrl_o_q;
   logic                   wrh_o_q;
   logic                   ack_o_q;
   logic                   ack_oe_q;

   // Reset input is async: two flops, only the second is read
   always_ff @(posedge mclk) begin
      rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], rst_in_async};
   end
   assign rst = rst_sync_q[SYNC_STAGES-1];

   // Request queue lets the user run ahead of bus grant
   ebp_fifo #(.WIDTH($bits(ebp_req_t)), .DEPTH(FIFO_DEPTH)) u_q (
      .mclk      (mclk),
      .rst       (rst),
      .in_data   (req),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   // Slave select: strobe sampled at rising edge with a window hit
   assign slv_sel = !bus_grant && ebp_hit(bus.address_bus)
                    && (bus.rd_n == STB_ACT || bus.write_low_strobe_n == STB_ACT
                        || bus.write_high_strobe_n == STB_ACT);
   assign fifo_pop = (st_q == ST_IDLE) && bus_grant && fifo_valid && !float_bus;

   // Reset-complete counter: stays low until hold time runs out after release
   always_ff @(posedge mclk) begin
      if (rst) begin
         rst_cnt_q    <= '0;
         reset_done_q <= 1'b0;
      end else if (rst_cnt_q != RST_CNT_W'(RST_HOLD_CYC)) begin
         rst_cnt_q <= RST_CNT_W'(rst_cnt_q + 1'b1);
      end else begin
         reset_done_q <= 1'b1;
      end
   end

   // Sequencer: master access, slave service, reset hold
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q  <= ST_RESET;
         cur_q <= '0;
      end else begin
         unique case (st_q)
            ST_RESET: if (reset_done_q) st_q <= ST_IDLE;
            ST_IDLE: begin
               if (fifo_pop) begin
                  cur_q <= fifo_out;
                  st_q  <= ST_ADDR;
               end else if (slv_sel) begin
                  st_q <= ST_SLAVE;
               end
            end
            ST_ADDR: st_q <= ST_DATA;
            ST_DATA: if (bus.ack) st_q <= ST_IDLE;
            // Ack is released a cycle before read data, so the master takes data while it stands;
            // leaving after one cycle avoids a second select on strobes the master still holds
            ST_SLAVE: if (!slave_wait) st_q <= ST_SLV_END;
            ST_SLV_END: st_q <= ST_IDLE;
         endcase
      end
   end

   // Address and strobes switch together on the same edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         addr_oe_q <= 1'b0;
         ctl_oe_q  <= 1'b0;
         addr_o_q  <= ADDR_RST;
         rd_o_q    <= STB_IDLE;
         wrl_o_q   <= STB_IDLE;
         wrh_o_q   <= STB_IDLE;
      end else if (fifo_pop) begin
         addr_oe_q <= 1'b1;
         ctl_oe_q  <= 1'b1;
         addr_o_q  <= fifo_out.addr;
         rd_o_q    <= fifo_out.write ? STB_IDLE : STB_ACT;
         wrl_o_q   <= (fifo_out.write && (fifo_out.wide32 || fifo_out.full64
                       || !fifo_out.addr[0])) ? STB_ACT : STB_IDLE;
         wrh_o_q   <= (fifo_out.write && !fifo_out.wide32 && (fifo_out.full64
                       || fifo_out.addr[0])) ? STB_ACT : STB_IDLE;
      end else if ((st_q == ST_DATA && bus.ack) || float_bus || !bus_grant) begin
         addr_oe_q <= 1'b0;
         ctl_oe_q  <= 1'b0;
         rd_o_q    <= STB_IDLE;
         wrl_o_q   <= STB_IDLE;
         wrh_o_q   <= STB_IDLE;
      end
   end

   // Data bus: driven for master writes and slave reads
   always_ff @(posedge mclk) begin
      if (rst) begin
         data_oe_q <= 1'b0;
         data_o_q  <= DATA_RST;
      end else if (st_q == ST_ADDR && cur_q.write && !float_bus) begin
         data_oe_q <= 1'b1;
         data_o_q  <= cur_q.addr[0] && !cur_q.full64
                      ? {cur_q.data[HALF_W-1:0], cur_q.data[HALF_W-1:0]} : cur_q.data;
      end else if (st_q == ST_IDLE && slv_sel && bus.rd_n == STB_ACT && !float_bus) begin
         data_oe_q <= 1'b1;
         data_o_q  <= mem_q[bus.address_bus[MEM_AW-1:0]];
      end else if ((st_q == ST_DATA && bus.ack) || st_q == ST_SLV_END || float_bus) begin
         data_oe_q <= 1'b0;
      end
   end

   // Slave acknowledge: pulled low while the user holds off
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_oe_q <= 1'b0;
         ack_o_q  <= 1'b1;
      end else begin
         ack_oe_q <= (st_q == ST_IDLE && slv_sel) || (st_q == ST_SLAVE && slave_wait);
         ack_o_q  <= 1'b0;
      end
   end

   // Internal memory written by the far master, low and high halves apart
   always_ff @(posedge mclk) begin
      if (st_q == ST_SLAVE && !slave_wait) begin
         if (bus.write_low_strobe_n == STB_ACT)
            mem_q[bus.address_bus[MEM_AW-1:0]][HALF_W-1:0] <= bus.data_bus[HALF_W-1:0];
         if (bus.write_high_strobe_n == STB_ACT)
            mem_q[bus.address_bus[MEM_AW-1:0]][DATA_W-1:HALF_W] <= bus.data_bus[DATA_W-1:HALF_W];
      end
   end

   // Read answer captured when the slave acknowledges
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_valid_q <= 1'b0;
         rd_data_q  <= DATA_RST;
      end else begin
         rd_valid_q <= st_q == ST_DATA && bus.ack && !cur_q.write;
         if (st_q == ST_DATA && bus.ack && !cur_q.write) rd_data_q <= bus.data_bus;
      end
   end

   // Pin outputs straight from flops
   assign bus.dev_addr_o   = addr_o_q;
   assign bus.dev_addr_oe  = addr_oe_q;
   assign bus.dev_data_o   = data_o_q;
   assign bus.dev_data_oe  = data_oe_q;
   assign bus.dev_rd_o     = rd_o_q;
   assign bus.dev_wrl_o    = wrl_o_q;
   assign bus.dev_wrh_o    = wrh_o_q;
   assign bus.dev_ctl_oe   = ctl_oe_q;
   assign bus.dev_ack_o    = ack_o_q;
   assign bus.dev_ack_oe   = ack_oe_q;
   assign bus.dev_rst_done = reset_done_q;
endmodule : ebp_dev

/* File: ebp_pkg.sv */
// Purpose: Shared constants and types for the external bus port ends
// Assumes: One system clock, synchronous active-high reset
// Notes:   Strobes are active low on the wire, as on the pins
package ebp_pkg;
   localparam int ADDR_W        = 32;
   localparam int DATA_W        = 64;
   localparam int HALF_W        = 32;
   localparam int FIFO_DEPTH    = 16;
   localparam int MEM_AW        = 8;               // Internal memory address bits; 2**MEM_AW words reachable by slaves
   localparam int SYNC_STAGES   = 2;
   localparam int RST_HOLD_CYC  = 8;               // Count end value; reset-complete rises one cycle after the count reaches it
   localparam int RST_CNT_W     = 4;
   localparam logic [ADDR_W-1:0] SLAVE_BASE = 32'h0000_0000; // Own window base
   localparam logic [ADDR_W-1:0] SLAVE_MASK = 32'hFFFF_FF00; // Window decode mask
   localparam logic [ADDR_W-1:0] ADDR_RST   = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DATA_RST   = 64'h0000_0000_0000_0000;
   localparam logic              STB_IDLE   = 1'b1;
   localparam logic              STB_ACT    = 1'b0;

   // Request from user side of master end
   typedef struct packed {
      logic              write;
      logic              wide32;   // Target zone configured for 32-bit bus
      logic              full64;   // Full 64-bit write
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } ebp_req_t;

   // True when address falls in this end's slave window
   function automatic logic ebp_hit(input logic [ADDR_W-1:0] a);
      return (a & SLAVE_MASK) == SLAVE_BASE;
   endfunction : ebp_hit
endpackage : ebp_pkg

/* File: ebp_if.sv */
// Purpose: Shared pin bundle between device end and external master end
// Assumes: Each driver gives data, output and enable; resolution here
// Notes:   Undriven strobes and ack resolve high like pull-ups
`timescale 1ns/1ps
interface ebp_if;
   import ebp_pkg::*;
   // Device drives
   logic [ADDR_W-1:0] dev_addr_o;
   logic              dev_addr_oe;
   logic [DATA_W-1:0] dev_data_o;
   logic              dev_data_oe;
   logic              dev_rd_o;
   logic              dev_wrl_o;
   logic              dev_wrh_o;
   logic              dev_ctl_oe;
   logic              dev_ack_o;
   logic              dev_ack_oe;
   logic              dev_rst_done;
   // Far master drives
   logic [ADDR_W-1:0] hst_addr_o;
   logic              hst_addr_oe;
   logic [DATA_W-1:0] hst_data_o;
   logic              hst_data_oe;
   logic              hst_rd_o;
   logic              hst_wrl_o;
   logic              hst_wrh_o;
   logic              hst_ctl_oe;
   logic              hst_ack_o;
   logic              hst_ack_oe;
   // Resolved wire levels
   logic [ADDR_W-1:0] address_bus;
   logic [DATA_W-1:0] data_bus;
   logic              rd_n;
   logic              write_low_strobe_n;
   logic              write_high_strobe_n;
   logic              ack;

   // Wired resolution with pull-up on idle
   assign address_bus         = dev_addr_oe ? dev_addr_o : hst_addr_oe ? hst_addr_o : '1;
   assign data_bus            = dev_data_oe ? dev_data_o : hst_data_oe ? hst_data_o : '1;
   assign rd_n                = dev_ctl_oe ? dev_rd_o : hst_ctl_oe ? hst_rd_o : 1'b1;
   assign write_low_strobe_n  = dev_ctl_oe ? dev_wrl_o : hst_ctl_oe ? hst_wrl_o : 1'b1;
   assign write_high_strobe_n = dev_ctl_oe ? dev_wrh_o : hst_ctl_oe ? hst_wrh_o : 1'b1;
   assign ack                 = (dev_ack_oe ? dev_ack_o : 1'b1) & (hst_ack_oe ? hst_ack_o : 1'b1);

   modport dev (
      output dev_addr_o, dev_addr_oe, dev_data_o, dev_data_oe, dev_rd_o, dev_wrl_o,
             dev_wrh_o, dev_ctl_oe, dev_ack_o, dev_ack_oe, dev_rst_done,
      input  address_bus, data_bus, rd_n, write_low_strobe_n, write_high_strobe_n, ack
   );
   modport host (
      output hst_addr_o, hst_addr_oe, hst_data_o, hst_data_oe, hst_rd_o, hst_wrl_o,
             hst_wrh_o, hst_ctl_oe, hst_ack_o, hst_ack_oe,
      input  address_bus, data_bus, rd_n, write_low_strobe_n, write_high_strobe_n, ack, dev_rst_done
   );
endinterface : ebp_if

/* File: ebp_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty are exact; no fall-through bypass
`timescale 1ns/1ps
module ebp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Handshakes
   assign in_ready  = (cnt_q != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage; no reset needed for data words
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= PW'(wr_q + 1'b1);
         if (pop)  rd_q <= PW'(rd_q + 1'b1);
         cnt_q <= (PW+1)'(cnt_q + push - pop);
      end
   end
endmodule : ebp_fifo

/* File: ebp_host.sv */
// Purpose: Far master end: host processor reaching the device internal memory
// Assumes: Device has signalled reset complete before use
// Notes:   One access at a time; waits on acknowledge
`timescale 1ns/1ps
module ebp_host
   import ebp_pkg::*;
(
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // User requests
   input  wire logic         req_valid,
   input  wire ebp_req_t     req,
   output logic              req_ready_q,
   // Read answers
   output logic [DATA_W-1:0] rd_data_q,
   output logic              rd_valid_q,
   // Pins
   ebp_if.host               bus
);
   typedef enum logic [1:0] {H_IDLE, H_ADDR, H_WAIT} ebp_hstate_t;
   ebp_hstate_t       st_q;
   ebp_req_t          cur_q;
   logic              oe_q;

   // Access sequencer; address and strobes rise together
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q        <= H_IDLE;
         cur_q       <= '0;
         oe_q        <= 1'b0;
         req_ready_q <= 1'b0;
         rd_valid_q  <= 1'b0;
         rd_data_q   <= DATA_RST;
      end else begin
         rd_valid_q  <= 1'b0;
         req_ready_q <= st_q == H_IDLE && bus.dev_rst_done && !req_ready_q;
         unique case (st_q)
            H_IDLE: if (req_valid && req_ready_q) begin
               cur_q <= req;
               oe_q  <= 1'b1;
               st_q  <= H_ADDR;
            end
            H_ADDR: st_q <= H_WAIT;
            H_WAIT: if (bus.ack) begin
               oe_q       <= 1'b0;
               rd_valid_q <= !cur_q.write;
               rd_data_q  <= bus.data_bus;
               st_q       <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // Pin drive; low-word strobe for low half, high strobe for high half
   assign bus.hst_addr_o  = cur_q.addr;
   assign bus.hst_addr_oe = oe_q;
   assign bus.hst_ctl_oe  = oe_q;
   assign bus.hst_rd_o    = cur_q.write ? STB_IDLE : STB_ACT;
   assign bus.hst_wrl_o   = (cur_q.write && (cur_q.full64 || !cur_q.addr[0])) ? STB_ACT : STB_IDLE;
   assign bus.hst_wrh_o   = (cur_q.write && (cur_q.full64 || cur_q.addr[0])) ? STB_ACT : STB_IDLE;
   assign bus.hst_data_o  = cur_q.data;
   assign bus.hst_data_oe = oe_q && cur_q.write;
   assign bus.hst_ack_o   = 1'b1;
   assign bus.hst_ack_oe  = 1'b0;
endmodule : ebp_host

/* File: ebp_props.sv */
// Purpose: Wire-level checks between device end and far master end
// Assumes: One clock; rst resets both ends
// Notes:   Watches only what the two ends drive, never the bench
`timescale 1ns/1ps
module ebp_props
   import ebp_pkg::*;
(
   // Clock and reset
   input wire logic              mclk,
   input wire logic              rst,
   // Device drives
   input wire logic [ADDR_W-1:0] dev_addr_o,
   input wire logic              dev_addr_oe,
   input wire logic              dev_data_oe,
   input wire logic              dev_rd_o,
   input wire logic              dev_wrl_o,
   input wire logic              dev_wrh_o,
   input wire logic              dev_ctl_oe,
   input wire logic              dev_ack_o,
   input wire logic              dev_ack_oe,
   input wire logic              dev_rst_done,
   // Far master drives
   input wire logic [ADDR_W-1:0] hst_addr_o,
   input wire logic              hst_addr_oe,
   input wire logic              hst_ctl_oe,
   // Resolved wires
   input wire logic [ADDR_W-1:0] address_bus,
   input wire logic              rd_n,
   input wire logic              ack
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic hit;

   // Window decode, kept apart from the design's helper
   assign hit = (address_bus & SLAVE_MASK) == SLAVE_BASE;

   a_reset_tristate: assert property (
      !dev_rst_done |-> !(dev_addr_oe || dev_data_oe || dev_ctl_oe || dev_ack_oe))
      else $error("device drove a pin before reset complete");
   a_one_ctl_driver: assert property (
      !(dev_ctl_oe && hst_ctl_oe)) else $error("two strobe drivers");
   a_one_addr_driver: assert property (
      !(dev_addr_oe && hst_addr_oe)) else $error("two address drivers");
   a_strobe_with_addr: assert property (
      dev_ctl_oe == dev_addr_oe) else $error("strobe enable apart from address");
   a_strobe_stable: assert property (
      dev_ctl_oe && $past(dev_ctl_oe) && $stable(dev_addr_o) |-> $stable({dev_rd_o, dev_wrl_o, dev_wrh_o}))
      else $error("strobe moved without address");
   a_read_no_write: assert property (
      dev_ctl_oe && !dev_rd_o |-> dev_wrl_o && dev_wrh_o) else $error("read and write strobes together");
   a_write_data_on: assert property (
      $rose(dev_ctl_oe) && !(dev_wrl_o && dev_wrh_o) |=> dev_data_oe) else $error("write data not driven");
   a_slave_ack_low: assert property (
      $rose(hst_ctl_oe) && hit |-> ##[1:2] (dev_ack_oe && !dev_ack_o)) else $error("slave did not take access");
   a_slave_read_out: assert property (
      $rose(hst_ctl_oe) && hit && !rd_n |-> ##[1:3] dev_data_oe) else $error("slave read data not driven");
   a_unmapped_quiet: assert property (
      $rose(hst_ctl_oe) && !hit |=> (!dev_ack_oe && !dev_data_oe) [*3]) else $error("unmapped access answered");
   a_master_holds: assert property (
      hst_ctl_oe && !ack |=> hst_ctl_oe && $stable(hst_addr_o)) else $error("master left a wait state");

   // Main traffic kinds
   c_dev_write: cover property ($rose(dev_ctl_oe) && !dev_wrl_o);
   c_host_read: cover property ($rose(hst_ctl_oe) && hit && !rd_n);
   c_wait_state: cover property (hst_ctl_oe && !ack [*3]);
endmodule : ebp_props

/* File: ebp_tb_top.sv */
// Purpose: Both ends of the bus port joined, driven from their user sides
// Assumes: No far agent acks device master cycles, so the pull-up ends them
// Notes:   Odd-word slave writes are not read back; word mapping is open
`timescale 1ns/1ps
module ebp_tb_top
   import ebp_pkg::*;
;
   logic              mclk = 1'b0;
   logic              rst = 1'b1;
   logic              d_valid = 1'b0, bus_grant = 1'b0, float_bus = 1'b0, slave_wait = 1'b0;
   logic              h_valid = 1'b0;
   ebp_req_t          d_req = '0, h_req = '0;
   logic              d_ready, d_rd_valid, reset_done_q, h_ready, h_rd_valid;
   logic [DATA_W-1:0] d_rd_data, h_rd_data, rd;
   int                fail_count = 0, check_count = 0, cyc = 0, n, t0;

   ebp_if bus_if ();
   ebp_dev i_ebp_dev (.mclk(mclk), .rst_in_async(rst), .req_valid(d_valid), .req_ready(d_ready),
      .req(d_req), .bus_grant(bus_grant), .float_bus(float_bus), .rd_data_q(d_rd_data),
      .rd_valid_q(d_rd_valid), .slave_wait(slave_wait), .reset_done_q(reset_done_q), .bus(bus_if));
   ebp_host i_ebp_host (.mclk(mclk), .rst(rst), .req_valid(h_valid), .req(h_req), .req_ready_q(h_ready),
      .rd_data_q(h_rd_data), .rd_valid_q(h_rd_valid), .bus(bus_if));
   ebp_props i_ebp_props (.mclk(mclk), .rst(rst), .dev_addr_o(bus_if.dev_addr_o),
      .dev_addr_oe(bus_if.dev_addr_oe), .dev_data_oe(bus_if.dev_data_oe), .dev_rd_o(bus_if.dev_rd_o),
      .dev_wrl_o(bus_if.dev_wrl_o), .dev_wrh_o(bus_if.dev_wrh_o), .dev_ctl_oe(bus_if.dev_ctl_oe),
      .dev_ack_o(bus_if.dev_ack_o), .dev_ack_oe(bus_if.dev_ack_oe), .dev_rst_done(bus_if.dev_rst_done),
      .hst_addr_o(bus_if.hst_addr_o), .hst_addr_oe(bus_if.hst_addr_oe), .hst_ctl_oe(bus_if.hst_ctl_oe),
      .address_bus(bus_if.address_bus), .rd_n(bus_if.rd_n), .ack(bus_if.ack));

   // Clock and cycle count
   always #5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // Device master push; held until the FIFO takes it
   task automatic d_push(input logic w, z, f, input logic [31:0] a);
      d_req <= '{write: w, wide32: z, full64: f, addr: a, data: {a, ~a}};
      d_valid <= 1'b1;
      #1;
      n = 0;
      while (d_ready !== 1'b1 && n < 50) begin @(posedge mclk); #1; n++; end
      check(d_ready, 1'b1);
      @(posedge mclk);
      d_valid <= 1'b0;
   endtask : d_push

   // Watch the wire while the device is master; strobes expected from the pairing rules
   task automatic d_watch(input logic w, z, f, input logic [31:0] a);
      n = 0;
      #1;
      while (bus_if.dev_ctl_oe !== 1'b1 && n < 50) begin @(posedge mclk); #1; n++; end
      check(bus_if.address_bus, a);
      check(bus_if.rd_n, w);
      check(bus_if.write_low_strobe_n, !(w && (!a[0] || z || f)));
      check(bus_if.write_high_strobe_n, !(w && (a[0] || f) && !z));
      @(posedge mclk);
      #1;
      // Odd-word halves go out on both lanes; data pattern is {addr, ~addr}
      if (w) check(bus_if.data_bus, (a[0] && !f) ? {~a, ~a} : {a, ~a});
      while (bus_if.dev_ctl_oe !== 1'b0 && n < 100) begin @(posedge mclk); #1; n++; end
      check(bus_if.dev_ctl_oe, 1'b0);
      // Nobody answers device reads, so the pulled-up bus comes back
      if (!w) check(d_rd_valid, 1'b1);
      if (!w) check(d_rd_data, '1);
      @(posedge mclk);
   endtask : d_watch

   // Far master access; waits for its own ready pulse and completion
   task automatic h_access(input logic w, f, input logic [31:0] a, input logic [63:0] dt, output logic [63:0] q);
      h_req <= '{write: w, wide32: 1'b0, full64: f, addr: a, data: dt};
      h_valid <= 1'b1;
      #1;
      n = 0;
      while (h_ready !== 1'b1 && n < 100) begin @(posedge mclk); #1; n++; end
      check(h_ready, 1'b1);
      @(posedge mclk);
      h_valid <= 1'b0;
      #1;
      while (bus_if.hst_ctl_oe !== 1'b1 && n < 100) begin @(posedge mclk); #1; n++; end
      while (bus_if.hst_ctl_oe !== 1'b0 && h_rd_valid !== 1'b1 && n < 200) begin @(posedge mclk); #1; n++; end
      while (!w && h_rd_valid !== 1'b1 && n < 210) begin @(posedge mclk); #1; n++; end
      check(bus_if.hst_ctl_oe, 1'b0);
      if (!w) check(h_rd_valid, 1'b1);
      q = h_rd_data;
      repeat (3) @(posedge mclk);
   endtask : h_access

   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      conclude();
   end

   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      repeat (8) begin
         @(posedge mclk);
         #1;
         check(reset_done_q, 1'b0);
         check(bus_if.write_low_strobe_n, 1'b1);
      end
      n = 0;
      while (reset_done_q !== 1'b1 && n < 20) begin @(posedge mclk); #1; n++; end
      check(bus_if.dev_rst_done, 1'b1);
      repeat (4) @(posedge mclk);
      // Far master writes, reads back, merges low half, misses the window
      h_access(1'b1, 1'b1, 32'h0000_0004, 64'h1122_3344_5566_7788, rd);
      h_access(1'b0, 1'b0, 32'h0000_0004, '0, rd);
      check(rd, 64'h1122_3344_5566_7788);
      h_access(1'b1, 1'b0, 32'h0000_0004, 64'hAAAA_AAAA_99AA_BBCC, rd);
      h_access(1'b1, 1'b1, 32'h0000_0104, 64'hDEAD_DEAD_DEAD_DEAD, rd);
      slave_wait <= 1'b1;
      fork
         begin repeat (8) @(posedge mclk); slave_wait <= 1'b0; end
      join_none
      t0 = cyc;
      h_access(1'b0, 1'b0, 32'h0000_0004, '0, rd);
      check(rd, 64'h1122_3344_99AA_BBCC);
      check(cyc - t0 >= 8, 1'b1);
      // Fill the request FIFO while not master, then drain it
      d_req <= '{write: 1'b1, wide32: 1'b0, full64: 1'b1, addr: 32'h0000_0200, data: 64'h0000_0200_FFFF_FDFF};
      d_valid <= 1'b1;
      t0 = 0;
      repeat (20) begin #1; if (d_ready === 1'b1) t0++; @(posedge mclk); end
      d_valid <= 1'b0;
      check(t0, FIFO_DEPTH);
      check(bus_if.dev_ctl_oe, 1'b0);
      bus_grant <= 1'b1;
      repeat (16) d_watch(1'b1, 1'b0, 1'b1, 32'h0000_0200);
      check(d_ready, 1'b1);
      // Each strobe pairing case once
      for (int k = 0; k < 5; k++) begin
         logic [2:0] c;
         c = (k == 0) ? 3'h0 : (k == 3) ? 3'h6 : (k == 4) ? 3'h5 : 3'h4;
         d_push(c[2], c[1], c[0], 32'h0000_0010 | (k == 2 || k == 3));
         d_watch(c[2], c[1], c[0], 32'h0000_0010 | (k == 2 || k == 3));
      end
      // Floated while master: nothing may drive
      float_bus <= 1'b1;
      d_push(1'b0, 1'b0, 1'b0, 32'h0000_0020);
      repeat (10) begin
         @(posedge mclk);
         #1;
         check({bus_if.dev_ctl_oe, bus_if.dev_addr_oe, bus_if.dev_data_oe}, 3'h0);
      end
      @(posedge mclk);
      float_bus <= 1'b0;
      d_watch(1'b0, 1'b0, 1'b0, 32'h0000_0020);
      repeat (4) @(posedge mclk);
      conclude();
   end
endmodule : ebp_tb_top
